// [rtl/rgp_top.sv]
// Two reduced-gigabit ports plus the management clock and data master.
// Assumes an external PHY that makes the receive clocks and answers MDIO.
`timescale 1ns/1ps
module rgp_top
  import rgp_pkg::*;
(
  input  wire logic                          clk,          // System clock, 20 MHz
  input  wire logic                          reset_n,      // Asynchronous reset, active low
  input  wire logic [rgp_pkg::NUM_PORTS-1:0] speed_100,    // Per port: 1 = 100 Mbit/s
  input  wire logic [rgp_pkg::NUM_PORTS-1:0] rxc,          // Receive clock pins
  input  wire logic [rgp_pkg::NUM_PORTS-1:0][3:0] rxd,     // Receive nibble pins
  input  wire logic [rgp_pkg::NUM_PORTS-1:0] rxctl,        // Receive control pins
  output logic      [rgp_pkg::NUM_PORTS-1:0][7:0] rx_data, // Received bytes
  output logic      [rgp_pkg::NUM_PORTS-1:0] rx_dv,        // Byte valid flags
  output logic      [rgp_pkg::NUM_PORTS-1:0] rx_err,       // Byte error flags
  output logic      [rgp_pkg::NUM_PORTS-1:0] rx_strobe,    // Byte pulses
  input  wire logic [rgp_pkg::NUM_PORTS-1:0][7:0] tx_data, // Bytes to send
  input  wire logic [rgp_pkg::NUM_PORTS-1:0] tx_en,        // Transmit enables
  input  wire logic [rgp_pkg::NUM_PORTS-1:0] tx_err,       // Transmit errors
  output logic      [rgp_pkg::NUM_PORTS-1:0] tx_take,      // Byte taken pulses
  output logic      [rgp_pkg::NUM_PORTS-1:0] txc,          // Transmit clock pins
  output logic      [rgp_pkg::NUM_PORTS-1:0][3:0] txd,     // Transmit nibble pins
  output logic      [rgp_pkg::NUM_PORTS-1:0] txctl,        // Transmit control pins
  input  wire logic                          mgmt_start,   // Start a frame
  input  wire logic                          mgmt_read,    // 1: read, 0: write
  input  wire logic [4:0]                    mgmt_phy,     // PHY address
  input  wire logic [4:0]                    mgmt_reg,     // Register address
  input  wire logic [15:0]                   mgmt_wdata,   // Write data
  output logic                               mgmt_busy,    // Frame in progress
  output logic                               mgmt_done,    // Pulse at frame end
  output logic      [15:0]                   mgmt_rdata,   // Read data
  output logic                               mdc,          // Management clock pin
  input  wire logic                          mdio_i,       // Management data in
  output logic                               mdio_o,       // Management data out
  output logic                               mdio_oe       // High while driving
);
  import rgp_pkg::*;

  // ------------------------------------------------------------------
  // Port instances
  // ------------------------------------------------------------------
  // Each port stands alone; they share only clk and reset
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port  // [RL1]
    rgp_port u_port (
      .clk       (clk),
      .reset_n   (reset_n),
      .speed_100 (speed_100[p]),
      .rxc       (rxc[p]),
      .rxd       (rxd[p]),
      .rxctl     (rxctl[p]),
      .rx_data   (rx_data[p]),
      .rx_dv     (rx_dv[p]),
      .rx_err    (rx_err[p]),
      .rx_strobe (rx_strobe[p]),
      .tx_data   (tx_data[p]),
      .tx_en     (tx_en[p]),
      .tx_err    (tx_err[p]),
      .tx_take   (tx_take[p]),
      .txc       (txc[p]),
      .txd       (txd[p]),
      .txctl     (txctl[p])
    );
  end

  // ------------------------------------------------------------------
  // Management data input synchroniser
  // ------------------------------------------------------------------
  logic mdi_s1_q, mdi_s2_q;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdi_s1_q <= 1'b1;
      mdi_s2_q <= 1'b1;
    end else begin
      mdi_s1_q <= mdio_i;
      mdi_s2_q <= mdi_s1_q;
    end
  end

  // ------------------------------------------------------------------
  // Frame sequencer state
  // ------------------------------------------------------------------
  rgp_mdio_state_t      state_q, state_d;
  logic [FRAME_BITS-1:0] frame_q;
  logic [5:0]            bit_q;
  logic [3:0]            mdiv_q;
  logic                  rd_q;

  // Frame assembled once; the shifter then walks it MSB first
  wire [FRAME_BITS-1:0] frame_load = {PREAMBLE, START_CODE,         // [RL11]
                                      mgmt_read ? OP_READ : OP_WRITE,
                                      mgmt_phy, mgmt_reg,
                                      mgmt_read ? TA_READ : TA_WRITE,
                                      mgmt_read ? 16'hffff : mgmt_wdata};
  wire       accept   = (state_q == RGP_IDLE) && mgmt_start;
  wire       half_end = (mdiv_q == 4'(MDC_HALF_CYC - 1));
  wire       mdc_rise = (state_q == RGP_RUN) && half_end && !mdc;
  wire       mdc_fall = (state_q == RGP_RUN) && half_end && mdc;
  wire       last_bit = (bit_q == 6'(FRAME_BITS - 1));
  wire [5:0] bit_nx   = bit_q + 6'h1;
  // Release the line for the turnaround and data bits of a read
  wire       drive_nx = !(rd_q && (bit_nx >= 6'(TA_BIT)));           // [RL11]

  // Next state decode
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RGP_IDLE: if (mgmt_start) state_d = RGP_RUN;
      RGP_RUN:  if (mdc_fall && last_bit) state_d = RGP_DONE;
      RGP_DONE: state_d = RGP_IDLE;
      default:  state_d = RGP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) state_q <= RGP_IDLE;
    else          state_q <= state_d;
  end

  // Management clock divider; runs only inside a frame
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdiv_q <= 4'h0;
      mdc <= 1'b0;
    end else if (state_q != RGP_RUN) begin
      mdiv_q <= 4'h0;
      mdc <= 1'b0;
    end else begin
      mdiv_q <= half_end ? 4'h0 : mdiv_q + 4'h1;
      if (half_end) mdc <= ~mdc;
    end
  end

  // ------------------------------------------------------------------
  // Bit launch and sampling
  // ------------------------------------------------------------------
  // First bit goes out at accept; the rest at each falling edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frame_q <= '0;
      bit_q <= 6'h0;
      rd_q <= 1'b0;
      mdio_o <= 1'b1;
      mdio_oe <= 1'b0;
    end else if (accept) begin
      frame_q <= frame_load;
      bit_q <= 6'h0;
      rd_q <= mgmt_read;
      mdio_o <= frame_load[FRAME_BITS-1];                            // [RL11]
      mdio_oe <= 1'b1;
    end else if (mdc_fall) begin
      frame_q <= {frame_q[FRAME_BITS-2:0], 1'b0};
      bit_q <= bit_nx;
      mdio_o <= last_bit ? 1'b1 : frame_q[FRAME_BITS-2];             // [RL10]
      mdio_oe <= !last_bit && drive_nx;                              // [RL10]
    end
  end

  // Read data is shifted in only on rising management clock edges
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) mgmt_rdata <= 16'h0000;
    else if (mdc_rise && rd_q && bit_q >= 6'(DATA_BIT))
      mgmt_rdata <= {mgmt_rdata[14:0], mdi_s2_q};                    // [RL9]
  end

  // Status flags
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mgmt_busy <= 1'b0;
      mgmt_done <= 1'b0;
    end else begin
      mgmt_busy <= (state_d != RGP_IDLE);
      mgmt_done <= (state_q == RGP_RUN) && (state_d == RGP_DONE);
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_accept;
    state_q == RGP_IDLE && mgmt_start;
  endsequence

  sequence s_frame_end;
    ##[512:516] mgmt_done;
  endsequence

  a_frame_length: assert property (@(posedge clk) disable iff (!reset_n) // [RL11]
    s_accept |-> s_frame_end)
    else $error("management frame length wrong");
  a_mdc_half: assert property (@(posedge clk) disable iff (!reset_n) // [RL9]
    $rose(mdc) |-> mdc[*4] ##1 !mdc)
    else $error("management clock high phase wrong");
  a_launch_fall: assert property (@(posedge clk) disable iff (!reset_n) // [RL10]
    ($changed(mdio_o) && $past(mgmt_busy) && mgmt_busy) |-> $fell(mdc))
    else $error("management data changed off falling edge");
  a_sample_rise: assert property (@(posedge clk) disable iff (!reset_n) // [RL9]
    $changed(mgmt_rdata) |-> $rose(mdc) && rd_q)
    else $error("read data taken off rising edge");
  a_read_release: assert property (@(posedge clk) disable iff (!reset_n) // [RL11]
    (state_q == RGP_RUN && rd_q && bit_q >= 6'(TA_BIT)) |-> !mdio_oe)
    else $error("line driven during read turnaround");
  a_write_drive: assert property (@(posedge clk) disable iff (!reset_n) // [RL11]
    (state_q == RGP_RUN && !rd_q) |-> mdio_oe)
    else $error("line released during write frame");

endmodule : rgp_top

// [rtl/rgp_pkg.sv]
// Constants shared by the two reduced-gigabit ports and the management link.
// Assumes a single 20 MHz system clock; no software registers exist.
//
// Function
// [RL1] Two reduced-gigabit ports, numbered 0 and 1, each have their own clocks, nibbles and control.
// [RL2] A received byte takes bits 3-0 at the rising receive clock edge and bits 7-4 at the falling one.
// [RL3] The receive control line gives data-valid at the rising edge and error at the falling edge.
// [RL4] A sent byte puts bits 3-0 out at the rising transmit clock edge and bits 7-4 at the falling one.
// [RL5] The transmit control line gives enable at the rising edge and error at the falling edge.
// [RL6] The transmit clock pin always lags data and control by an internal delay that cannot be disabled.
// [RL7] The receive clock is delayed by the PHY or board; the port adds no delay of its own.
// [RL8] No port runs at gigabit speed; only 10 and 100 Mbit/s exist.
// [RL9] Incoming management data is sampled at the rising edge of the management clock.
// [RL10] Outgoing management data changes at the falling edge of the management clock.
// [RL11] Management frames are preamble, start, opcode, PHY and register address, turnaround, data.
// [RL12] The transmit clock period at 10 Mbit/s is ten times that at 100 Mbit/s; the code gives four times (4 against 1 clk cycles per half).
package rgp_pkg;

  // ------------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 50;
  localparam int NUM_PORTS       = 2;
  // Least half period of the management clock (160 ns), kept at 200 ns
  localparam int MDC_HALF_NS     = 200;
  localparam int MDC_HALF_CYC    = (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Transmit clock half periods for the two speeds, rounded down but never below one cycle
  localparam int TX_HALF_10_NS   = 200;
  localparam int TX_HALF_100_NS  = 20;
  localparam int TX_HALF_10_CYC  = (TX_HALF_10_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   TX_HALF_10_NS / CLK_PERIOD_NS;
  localparam int TX_HALF_100_CYC = (TX_HALF_100_NS / CLK_PERIOD_NS < 1) ? 1 :
                                   TX_HALF_100_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------------
  // Management frame layout
  // ------------------------------------------------------------------
  localparam int          FRAME_BITS = 64;
  localparam int          TA_BIT     = 46;
  localparam int          DATA_BIT   = 48;
  localparam logic [31:0] PREAMBLE   = 32'hffffffff;
  localparam logic [1:0]  START_CODE = 2'h1;
  localparam logic [1:0]  OP_READ    = 2'h2;
  localparam logic [1:0]  OP_WRITE   = 2'h1;
  localparam logic [1:0]  TA_WRITE   = 2'h2;
  localparam logic [1:0]  TA_READ    = 2'h3;

  typedef enum logic [2:0] {
    RGP_IDLE = 3'h1,
    RGP_RUN  = 3'h2,
    RGP_DONE = 3'h4
  } rgp_mdio_state_t;

endpackage : rgp_pkg

// [rtl/rgp_port.sv]
// One reduced-gigabit port: double-rate receive capture and transmit launch.
// Assumes the receive pins are asynchronous and sampled on clk.
`timescale 1ns/1ps
module rgp_port
  import rgp_pkg::*;
(
  input  wire logic       clk,        // System clock
  input  wire logic       reset_n,    // Asynchronous reset, active low
  input  wire logic       speed_100,  // 1: 100 Mbit/s, 0: 10 Mbit/s
  input  wire logic       rxc,        // Receive clock pin
  input  wire logic [3:0] rxd,        // Receive nibble pin
  input  wire logic       rxctl,      // Receive control pin
  output logic      [7:0] rx_data,    // Reassembled byte
  output logic            rx_dv,      // Byte valid indication
  output logic            rx_err,     // Byte error indication
  output logic            rx_strobe,  // One-cycle pulse per byte
  input  wire logic [7:0] tx_data,    // Byte to send
  input  wire logic       tx_en,      // Transmit enable for the byte
  input  wire logic       tx_err,     // Transmit error for the byte
  output logic            tx_take,    // Pulse: byte inputs taken
  output logic            txc,        // Transmit clock pin
  output logic      [3:0] txd,        // Transmit nibble pin
  output logic            txctl       // Transmit control pin
);
  import rgp_pkg::*;

  // ------------------------------------------------------------------
  // Receive synchronisers and edge finding
  // ------------------------------------------------------------------
  logic [3:0] rxd_s1_q, rxd_s2_q, lo_q;
  logic       rxc_s1_q, rxc_s2_q, rxc_s3_q, ctl_s1_q, ctl_s2_q, dv_q;
  wire        rx_rise = rxc_s2_q & ~rxc_s3_q;
  wire        rx_fall = ~rxc_s2_q & rxc_s3_q;

  // Same two-stage depth on clock and data keeps them aligned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      {rxc_s1_q, rxc_s2_q, rxc_s3_q} <= 3'h0;
      {ctl_s1_q, ctl_s2_q}           <= 2'h0;
      rxd_s1_q <= 4'h0;
      rxd_s2_q <= 4'h0;
    end else begin
      {rxc_s1_q, rxc_s2_q, rxc_s3_q} <= {rxc, rxc_s1_q, rxc_s2_q};
      {ctl_s1_q, ctl_s2_q}           <= {rxctl, ctl_s1_q};
      rxd_s1_q <= rxd;
      rxd_s2_q <= rxd_s1_q;
    end
  end

  // Low nibble and valid at rise, high nibble and error at fall
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lo_q <= 4'h0;
      dv_q <= 1'b0;
      rx_data <= 8'h00;
      rx_dv <= 1'b0;
      rx_err <= 1'b0;
      rx_strobe <= 1'b0;
    end else begin
      rx_strobe <= rx_fall;
      if (rx_rise) begin
        lo_q <= rxd_s2_q;                 // [RL2]
        dv_q <= ctl_s2_q;                 // [RL3]
      end
      if (rx_fall) begin
        rx_data <= {rxd_s2_q, lo_q};      // [RL2]
        rx_dv   <= dv_q;                  // [RL3]
        rx_err  <= ctl_s2_q;              // [RL3]
      end
    end
  end

  // ------------------------------------------------------------------
  // Transmit clock divider and launch
  // ------------------------------------------------------------------
  logic [3:0] div_q, hi_q;
  logic       phase_q, err_q;
  // Only two speeds exist; there is no gigabit setting at all
  wire  [3:0] half_m1 = speed_100 ? 4'(TX_HALF_100_CYC - 1)   // [RL8] [RL12]
                                  : 4'(TX_HALF_10_CYC - 1);
  wire        wrap    = (div_q >= half_m1);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 4'h0;
      phase_q <= 1'b0;
      hi_q <= 4'h0;
      err_q <= 1'b0;
      txd <= 4'h0;
      txctl <= 1'b0;
      tx_take <= 1'b0;
    end else begin
      div_q   <= wrap ? 4'h0 : div_q + 4'h1;
      tx_take <= wrap & ~phase_q;
      if (wrap) begin
        phase_q <= ~phase_q;
        if (!phase_q) begin
          txd   <= tx_data[3:0];          // [RL4]
          txctl <= tx_en;                 // [RL5]
          hi_q  <= tx_data[7:4];
          err_q <= tx_err;
        end else begin
          txd   <= hi_q;                  // [RL4]
          txctl <= err_q;                 // [RL5]
        end
      end
    end
  end

  // Pin clock lags the launch by one cycle; always on, no bypass
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) txc <= 1'b0;
    else          txc <= phase_q;         // [RL6]
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  a_rx_high_nibble: assert property (@(posedge clk) disable iff (!reset_n) // [RL2]
    rx_strobe |-> rx_data[7:4] == $past(rxd_s2_q))
    else $error("high nibble not taken at falling edge");
  a_rx_err_split: assert property (@(posedge clk) disable iff (!reset_n) // [RL3]
    rx_strobe |-> rx_err == $past(ctl_s2_q) && rx_dv == $past(dv_q))
    else $error("receive control not split by edge");
  a_tx_low_first: assert property (@(posedge clk) disable iff (!reset_n) // [RL4] [RL5]
    $rose(phase_q) |-> txd == $past(tx_data[3:0]) && txctl == $past(tx_en))
    else $error("low nibble or enable not on rising phase");
  a_txc_lags: assert property (@(posedge clk) disable iff (!reset_n) // [RL6]
    $rose(phase_q) |-> !txc ##1 txc)
    else $error("transmit clock pin not delayed");
  // A speed change inside a phase may cut the slow count short
  a_tx_slow_half: assert property (@(posedge clk) disable iff (!reset_n) // [RL12]
    (!speed_100 && $rose(phase_q)) |-> (phase_q || speed_100)[*4] ##1 (!phase_q || speed_100))
    else $error("10 Mbit/s half period wrong");

endmodule : rgp_port

// [dv/rgp_phy_model.sv]
// Behavioural stand-in for the external PHY: receive clocks and MDIO answers.
// Assumes MDC runs at 400 ns per period inside a frame and idles low between frames.
`timescale 1ns/1ps
module rgp_phy_model #(
  parameter logic [4:0] PHY_ADDR = 5'h05  // Address answered; value is arbitrary
) (
  input  wire logic       mdc,      // Management clock from the device
  input  wire logic       mdio_o,   // Device data out
  input  wire logic       mdio_oe,  // Device drive enable
  output logic            mdio_i,   // Resolved management wire
  output logic [1:0]      rxc,      // Receive clocks, still between bytes
  output logic [1:0][3:0] rxd,      // Receive nibbles
  output logic [1:0]      rxctl     // Receive control
);
  logic [63:0] sh;
  logic [15:0] regs [32];
  logic [15:0] rd;
  logic        drv;
  logic        drv_o;
  bit          rd_go;
  int          nb;
  realtime     last;

  // Pull-up on the wire when nobody drives
  assign mdio_i = mdio_oe ? mdio_o : (drv ? drv_o : 1'b1);

  initial begin
    rxc = '0;
    rxd = '0;
    rxctl = '0;
    drv = 1'b0;
    drv_o = 1'b1;
    nb = 0;
    last = 0;
    for (int i = 0; i < 32; i++) regs[i] = 16'h0000;
  end

  // ----------------------------------------------------------------
  // Receive side
  // ----------------------------------------------------------------
  // Clock edge lags the data by 50 ns; lines are inverted once the byte ends
  task automatic send_byte(input int p, input logic [7:0] b, input logic dv, input logic er);
    rxd[p] = b[3:0];
    rxctl[p] = dv;
    #50 rxc[p] = 1'b1;
    #150 rxd[p] = b[7:4];
    rxctl[p] = er;
    #50 rxc[p] = 1'b0;
    #150 rxd[p] = ~b[7:4];
    rxctl[p] = ~er;
  endtask : send_byte

  // ----------------------------------------------------------------
  // Management side
  // ----------------------------------------------------------------
  // Sample at the rise; a long idle restarts the bit count
  always @(posedge mdc) begin
    if ($realtime - last > 600.0) nb = 0;
    last = $realtime;
    sh = {sh[62:0], mdio_i};
    nb = nb + 1;
    if (nb == 1) rd_go = 1'b0;
    if (nb == 46) begin
      rd = regs[sh[4:0]];
      rd_go = (sh[45:14] == 32'hffffffff) && (sh[13:12] == 2'h1) && (sh[11:10] == 2'h2)
              && (sh[9:5] == PHY_ADDR);
    end
    if (nb == 64 && sh[63:32] == 32'hffffffff && sh[31:28] == 4'h5 && sh[27:23] == PHY_ADDR
        && sh[17:16] == 2'h2) begin
      regs[sh[22:18]] = sh[15:0];
    end
  end

  // Launch at the fall: turnaround zero, then sixteen bits, then release
  always @(negedge mdc) begin
    drv = rd_go && nb >= 47 && nb <= 63;
    drv_o = drv ? ((nb == 47) ? 1'b0 : rd[63-nb]) : 1'b1;
  end
endmodule : rgp_phy_model

// [dv/tb.sv]
// Self-checking bench for the two reduced-gigabit ports and the management master.
// Assumes the PHY model drives all receive pins and the management wire.
`timescale 1ns/1ps
module tb;
  import rgp_pkg::*;
  localparam logic [4:0] PHY_ADR = 5'h05;  // Arbitrary PHY address
  logic clk, reset_n, mgmt_start, mgmt_read, mgmt_busy, mgmt_done, mdc;
  logic mdio_i, mdio_o, mdio_oe;
  logic [4:0]  mgmt_phy, mgmt_reg;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [NUM_PORTS-1:0] speed_100, rxc, rxctl, rx_dv, rx_err, rx_strobe;
  logic [NUM_PORTS-1:0] tx_en, tx_err, tx_take, txc, txctl;
  logic [NUM_PORTS-1:0][3:0] rxd, txd;
  logic [NUM_PORTS-1:0][7:0] rx_data, tx_data;
  int   errors, cmp_count;

  rgp_top i_dut (.clk(clk), .reset_n(reset_n), .speed_100(speed_100), .rxc(rxc), .rxd(rxd),
    .rxctl(rxctl), .rx_data(rx_data), .rx_dv(rx_dv), .rx_err(rx_err), .rx_strobe(rx_strobe),
    .tx_data(tx_data), .tx_en(tx_en), .tx_err(tx_err), .tx_take(tx_take), .txc(txc),
    .txd(txd), .txctl(txctl), .mgmt_start(mgmt_start), .mgmt_read(mgmt_read),
    .mgmt_phy(mgmt_phy), .mgmt_reg(mgmt_reg), .mgmt_wdata(mgmt_wdata),
    .mgmt_busy(mgmt_busy), .mgmt_done(mgmt_done), .mgmt_rdata(mgmt_rdata), .mdc(mdc),
    .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe));
  rgp_phy_model #(.PHY_ADDR(PHY_ADR)) i_phy (.mdc(mdc), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
    .mdio_i(mdio_i), .rxc(rxc), .rxd(rxd), .rxctl(rxctl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic hang(input string what);
    errors++;
    $display("MISMATCH %s expected event seen timeout", what);
    wrap_up();
  endtask : hang

  // Drive and sample point: just after the rising edge
  task automatic tick();
    @(posedge clk);
    #2;
  endtask : tick

  task automatic wait_take(input int p);
    int k;
    for (k = 0; k < 40 && tx_take[p] !== 1'b1; k++) tick();
    if (k == 40) hang("tx_take");
  endtask : wait_take

  // Management data may only move while MDC is low
  always @(mdio_o) begin
    #1 if (reset_n === 1'b1 && mdio_oe === 1'b1) chk("mdio launch", 16'h0, {15'h0, mdc});
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic rx_case(input int p, input logic [7:0] b, input logic dv, input logic er);
    int k;
    fork
      i_phy.send_byte(p, b, dv, er);
      begin
        for (k = 0; k < 40 && rx_strobe[p] !== 1'b1; k++) tick();
        if (k == 40) hang("rx_strobe");
        chk("rx_data", {8'h00, b}, {8'h00, rx_data[p]});
        chk("rx_dv", {15'h0, dv}, {15'h0, rx_dv[p]});
        chk("rx_err", {15'h0, er}, {15'h0, rx_err[p]});
        tick();
        chk("rx_strobe width", 16'h0, {15'h0, rx_strobe[p]});
      end
    join
  endtask : rx_case

  task automatic tx_case(input int p, input logic spd, input logic [7:0] b, input logic en,
                         input logic er);
    int k;
    int h;
    h = spd ? TX_HALF_100_CYC : TX_HALF_10_CYC;
    speed_100[p] = spd;
    wait_take(p);
    tick();
    wait_take(p);
    tx_data[p] = b;
    tx_en[p] = en;
    tx_err[p] = er;
    for (k = 1; k <= 40; k++) begin
      tick();
      if (tx_take[p] === 1'b1) break;
    end
    chk("byte period", 16'(2 * h), 16'(k));
    chk("txd low", {12'h0, b[3:0]}, {12'h0, txd[p]});
    chk("txctl enable", {15'h0, en}, {15'h0, txctl[p]});
    chk("txc lag rise", 16'h0, {15'h0, txc[p]});
    repeat (h) tick();
    chk("txd high", {12'h0, b[7:4]}, {12'h0, txd[p]});
    chk("txctl error", {15'h0, er}, {15'h0, txctl[p]});
    chk("txc lag fall", 16'h1, {15'h0, txc[p]});
    tick();
    chk("txc low", 16'h0, {15'h0, txc[p]});
  endtask : tx_case

  // Start held three cycles: the copies seen while busy must be ignored
  task automatic mgmt_case(input logic rd, input logic [4:0] phy, input logic [4:0] rg,
                           input logic [15:0] wd, input logic [15:0] exp);
    int k;
    mgmt_read = rd;
    mgmt_phy = phy;
    mgmt_reg = rg;
    mgmt_wdata = wd;
    mgmt_start = 1'b1;
    repeat (3) tick();
    mgmt_start = 1'b0;
    chk("mgmt busy", 16'h1, {15'h0, mgmt_busy});
    for (k = 3; k < 600 && mgmt_done !== 1'b1; k++) tick();
    if (k == 600) hang("mgmt_done");
    chk("frame length", 16'h1, {15'h0, (k >= 512 && k <= 517)});
    if (rd) chk("mgmt rdata", exp, mgmt_rdata);
    tick();
    chk("no second frame", 16'h0, {15'h0, mgmt_busy});
    repeat (12) tick();
  endtask : mgmt_case

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    errors = 0;
    cmp_count = 0;
    reset_n = 1'b0;
    speed_100 = '0;
    tx_data = '0;
    tx_en = '0;
    tx_err = '0;
    {mgmt_start, mgmt_read, mgmt_phy, mgmt_reg, mgmt_wdata} = '0;
    repeat (6) @(posedge clk);
    #2;
    chk("reset outputs", 16'h8000, {mdio_o, mdio_oe, mdc, txc, rx_strobe, tx_take, 7'h0});
    reset_n = 1'b1;
    rx_case(0, 8'ha5, 1'b1, 1'b0);
    rx_case(1, 8'h3c, 1'b1, 1'b1);
    rx_case(0, 8'h96, 1'b0, 1'b1);
    tx_case(0, 1'b0, 8'ha5, 1'b1, 1'b0);
    tx_case(1, 1'b1, 8'h3c, 1'b1, 1'b1);
    tx_case(0, 1'b1, 8'h69, 1'b0, 1'b1);
    tx_case(1, 1'b0, 8'h0f, 1'b0, 1'b0);
    mgmt_case(1'b0, PHY_ADR, 5'h03, 16'h5aa5, 16'h0000);
    mgmt_case(1'b1, PHY_ADR, 5'h03, 16'h0000, 16'h5aa5);
    mgmt_case(1'b0, PHY_ADR, 5'h1e, 16'h8001, 16'h0000);
    mgmt_case(1'b1, PHY_ADR, 5'h1e, 16'h0000, 16'h8001);
    mgmt_case(1'b1, PHY_ADR, 5'h07, 16'h0000, 16'h0000);
    mgmt_case(1'b1, 5'h1a, 5'h03, 16'h0000, 16'hffff);
    wrap_up();
  end

  // Watchdog against a stuck run
  initial begin
    #4000000;
    hang("run time");
  end
endmodule : tb
